/* File: design/mcar_alert.sv */
// Alert combiner: masks status conditions onto one alert request
`timescale 1ns/1ps
module mcar_alert
  import mcar_pkg::*;
(
  input  wire logic [7:0] mask_one_in,
  input  wire logic [7:0] mask_two_in,
  input  wire logic [7:0] status_one_in,
  input  wire logic [7:0] status_two_in,
  output logic            alert_req_out
);

  logic live_one;
  logic live_two;
  logic all_two_masked;
  logic any_two;

  // ==========================================================================
  // Masking
  always_comb begin
    live_one       = |(status_one_in & ~mask_one_in & ALERT1_SRC);
    live_two       = |(status_two_in & ~mask_two_in & ALERT2_SRC);
    all_two_masked = &(mask_two_in | ~ALERT2_SRC);
    any_two        = |(status_two_in & ALERT2_SRC);
    alert_req_out  = live_one | live_two |
                     (all_two_masked & any_two & ~mask_one_in[MASK1_GATE_BIT]);
  end

endmodule

/* File: design/mcar_pkg.sv */
// Package: constants and types of the monitor config and alert mask registers
// ==========================================================================
package mcar_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CFG2  = 8'h73;
  localparam logic [7:0] ADDR_MASK1 = 8'h74;
  localparam logic [7:0] ADDR_MASK2 = 8'h75;
  localparam logic [7:0] ADDR_VLOW  = 8'h76;
  localparam logic [7:0] ADDR_TLOW  = 8'h77;

  // ==========================================================================
  // Field positions
  localparam int unsigned CFG2_AVG_BIT   = 4;
  localparam int unsigned CFG2_ATTENUATOR_BYPASS_BIT  = 5;
  localparam int unsigned CFG2_SINGLE_CHANNEL_MODE_BIT  = 6;
  localparam int unsigned CFG2_SHUTDOWN_REQUEST_BIT  = 7;
  localparam int unsigned MASK1_GATE_BIT = 7;
  localparam int unsigned MASK2_OVT_BIT  = 1;
  localparam int unsigned MASK2_F4P_BIT  = 5;
  localparam int unsigned SEL_LSB        = 5;
  localparam int unsigned LOW_CORE_LSB   = 2;
  localparam int unsigned LOW_SUPPLY_LSB = 4;
  localparam int unsigned LOW_R1_LSB     = 2;
  localparam int unsigned LOW_LOCAL_LSB  = 4;
  localparam int unsigned LOW_R2_LSB     = 6;

  // ==========================================================================
  // Writable bits, alert sources and reset values
  localparam logic [7:0] CFG2_WR_MASK  = 8'hF0;
  localparam logic [7:0] MASK1_WR_MASK = 8'hF6;
  localparam logic [7:0] MASK2_WR_MASK = 8'hFC;
  localparam logic [7:0] ALERT1_SRC    = 8'h76;
  localparam logic [7:0] ALERT2_SRC    = 8'hFE;
  localparam logic [7:0] CFG2_RST      = 8'h00;
  localparam logic [7:0] MASK1_RST     = 8'h00;
  localparam logic [7:0] MASK2_RST     = 8'h00;
  localparam logic [7:0] READ_RST      = 8'h00;

  // ==========================================================================
  // Reading channels: 0 core voltage, 1 supply, 2 remote one, 3 local, 4 remote two
  localparam int unsigned NUM_CH  = 5;
  localparam int unsigned NUM_PWM = 3;

  typedef enum logic [2:0] {
    CH_RES0    = 3'b000,
    CH_CORE    = 3'b001,
    CH_SUPPLY  = 3'b010,
    CH_RES3    = 3'b011,
    CH_RES4    = 3'b100,
    CH_REMOTE1 = 3'b101,
    CH_LOCAL   = 3'b110,
    CH_REMOTE2 = 3'b111
  } mcar_chan_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mcar_reg_req_t;

  typedef struct packed {
    logic       diode_two_fault;
    logic       diode_one_fault;
    logic       thermal_timer_event;
    logic       fan_four_fault;
    logic [2:0] fan_fault;
    logic       overtemp;
  } mcar_status_two_t;

  typedef struct packed {
    logic [7:0]                    cfg2;
    logic [7:0]                    mask1;
    logic [7:0]                    mask2;
    logic [NUM_CH-1:0][1:0]        low_bits;
    logic [NUM_CH-1:0][7:0]        msb;
    logic [NUM_CH-1:0]             pending;
    logic [7:0]                    rdata;
    logic                          alert_n;
    logic [NUM_PWM-1:0]            pwm;
    logic [NUM_PWM-1:0][7:0]       duty_view;
    logic [NUM_CH-1:0]             single_channel_mode_en;
  } mcar_state_t;

endpackage

/* File: design/mcar_regs.sv */
// Configuration, alert mask and extended-resolution register group
`timescale 1ns/1ps
module mcar_regs
  import mcar_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire mcar_reg_req_t           reg_req_in,
  output logic [7:0]                   reg_rdata_out,
  input  wire logic                    config_lock_in,
  input  wire logic [7:0]              fan_one_min_high_in,
  input  wire logic [NUM_CH-1:0][9:0]  reading_in,
  input  wire logic                    meas_valid_in,
  input  wire logic [NUM_CH-1:0]       msb_read_in,
  output logic [NUM_CH-1:0][7:0]       msb_hold_out,
  input  wire logic [NUM_PWM-1:0]      pwm_drive_in,
  input  wire logic [NUM_PWM-1:0]      pwm_polarity_invert_in,
  input  wire logic [NUM_PWM-1:0][7:0] pwm_duty_in,
  output logic [NUM_PWM-1:0]           pwm_out,
  output logic [NUM_PWM-1:0][7:0]      pwm_duty_view_out,
  input  wire logic [7:0]              status_one_in,
  input  wire mcar_status_two_t        status_two_in,
  input  wire logic                    fan_four_tach_pin_in,
  input  wire logic                    overtemp_mask_in,
  output logic                         averaging_disable_out,
  output logic                         attenuator_bypass_out,
  output logic                         single_channel_mode_out,
  output logic                         shutdown_request_out,
  output logic [NUM_CH-1:0]            single_channel_mode_channel_en_out,
  output logic                         alert_n_out
);

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  mcar_state_t       s_ff;
  mcar_state_t       nxt_s;
  logic [7:0]        mask2_view;
  logic [7:0]        status_two_vec;
  logic              alert_req;
  logic              wr_cfg2;
  logic              shutdown;
  logic [NUM_CH-1:0] frz;

  // ==========================================================================
  // Functions
  function automatic logic [NUM_CH-1:0] chan_onehot(input logic [2:0] code);
    logic [NUM_CH-1:0] en;
    en = '0;
    case (mcar_chan_t'(code))
      CH_CORE:    en = 5'h01;
      CH_SUPPLY:  en = 5'h02;
      CH_REMOTE1: en = 5'h04;
      CH_LOCAL:   en = 5'h08;
      CH_REMOTE2: en = 5'h10;
      default:    en = '0;
    endcase
    return en;
  endfunction

  function automatic logic group_frozen(input logic [NUM_CH-1:0] pend,
                                        input int unsigned ch);
    logic f;
    f = (ch < 2) ? |pend[1:0] : |pend[4:2];
    return f;
  endfunction

  function automatic logic [NUM_CH-1:0] low_read_group(input mcar_reg_req_t req);
    logic [NUM_CH-1:0] g;
    g = '0;
    if (req.rd && (req.addr == ADDR_VLOW)) begin
      g[1:0] = 2'h3;
    end
    if (req.rd && (req.addr == ADDR_TLOW)) begin
      g[4:2] = 3'h7;
    end
    return g;
  endfunction

  function automatic logic [7:0] volt_low_view(input logic [NUM_CH-1:0][1:0] lb);
    logic [7:0] v;
    v = '0;
    v[LOW_CORE_LSB +: 2]   = lb[0];
    v[LOW_SUPPLY_LSB +: 2] = lb[1];
    return v;
  endfunction

  function automatic logic [7:0] temp_low_view(input logic [NUM_CH-1:0][1:0] lb);
    logic [7:0] v;
    v = '0;
    v[LOW_R1_LSB +: 2]    = lb[2];
    v[LOW_LOCAL_LSB +: 2] = lb[3];
    v[LOW_R2_LSB +: 2]    = lb[4];
    return v;
  endfunction

  // ==========================================================================
  // Alert sources
  always_comb begin
    mask2_view                = s_ff.mask2 & MASK2_WR_MASK;
    mask2_view[MASK2_OVT_BIT] = overtemp_mask_in;
    status_two_vec            = {status_two_in.diode_two_fault,
                                 status_two_in.diode_one_fault,
                                 fan_four_tach_pin_in ? status_two_in.thermal_timer_event
                                                      : status_two_in.fan_four_fault,
                                 status_two_in.fan_fault,
                                 status_two_in.overtemp,
                                 1'b0};
  end

  mcar_alert u_alert (
    .mask_one_in   (s_ff.mask1),
    .mask_two_in   (mask2_view),
    .status_one_in (status_one_in),
    .status_two_in (status_two_vec),
    .alert_req_out (alert_req)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_s    = s_ff;
    wr_cfg2  = reg_req_in.wr && (reg_req_in.addr == ADDR_CFG2) && !config_lock_in;
    shutdown = s_ff.cfg2[CFG2_SHUTDOWN_REQUEST_BIT];
    frz      = s_ff.pending | low_read_group(reg_req_in);

    if (wr_cfg2) begin
      nxt_s.cfg2 = reg_req_in.wdata & CFG2_WR_MASK;
    end
    if (reg_req_in.wr && (reg_req_in.addr == ADDR_MASK1)) begin
      nxt_s.mask1 = reg_req_in.wdata & MASK1_WR_MASK;
    end
    if (reg_req_in.wr && (reg_req_in.addr == ADDR_MASK2)) begin
      nxt_s.mask2 = reg_req_in.wdata & MASK2_WR_MASK;
    end

    // Readings update unless their group is frozen or read in this cycle
    for (int unsigned i = 0; i < NUM_CH; i++) begin
      if (meas_valid_in && !group_frozen(frz, i)) begin
        nxt_s.low_bits[i] = reading_in[i][1:0];
        nxt_s.msb[i]      = reading_in[i][9:2];
      end
    end

    // High-byte reads release; a new low-bit read wins over a release
    nxt_s.pending = (s_ff.pending & ~msb_read_in) | low_read_group(reg_req_in);

    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        ADDR_CFG2:  nxt_s.rdata = s_ff.cfg2;
        ADDR_MASK1: nxt_s.rdata = s_ff.mask1;
        ADDR_MASK2: nxt_s.rdata = mask2_view;
        ADDR_VLOW:  nxt_s.rdata = volt_low_view(s_ff.low_bits);
        ADDR_TLOW:  nxt_s.rdata = temp_low_view(s_ff.low_bits);
        default:    nxt_s.rdata = READ_RST;
      endcase
    end

    nxt_s.alert_n = !alert_req;

    for (int unsigned p = 0; p < NUM_PWM; p++) begin
      nxt_s.pwm[p]       = shutdown ? pwm_polarity_invert_in[p] : pwm_drive_in[p];
      nxt_s.duty_view[p] = shutdown ? 8'h00 : pwm_duty_in[p];
    end

    if (s_ff.cfg2[CFG2_SINGLE_CHANNEL_MODE_BIT]) begin
      nxt_s.single_channel_mode_en = chan_onehot(fan_one_min_high_in[SEL_LSB +: 3]);
    end else begin
      nxt_s.single_channel_mode_en = '1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff.cfg2      <= CFG2_RST;
      s_ff.mask1     <= MASK1_RST;
      s_ff.mask2     <= MASK2_RST;
      s_ff.low_bits  <= '0;
      s_ff.msb       <= '0;
      s_ff.pending   <= '0;
      s_ff.rdata     <= READ_RST;
      s_ff.alert_n   <= 1'b1;
      s_ff.pwm       <= '0;
      s_ff.duty_view <= '0;
      s_ff.single_channel_mode_en   <= '1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    reg_rdata_out           = s_ff.rdata;
    msb_hold_out            = s_ff.msb;
    pwm_out                 = s_ff.pwm;
    pwm_duty_view_out       = s_ff.duty_view;
    averaging_disable_out   = s_ff.cfg2[CFG2_AVG_BIT];
    attenuator_bypass_out   = s_ff.cfg2[CFG2_ATTENUATOR_BYPASS_BIT];
    single_channel_mode_out = s_ff.cfg2[CFG2_SINGLE_CHANNEL_MODE_BIT];
    shutdown_request_out    = s_ff.cfg2[CFG2_SHUTDOWN_REQUEST_BIT];
    single_channel_mode_channel_en_out     = s_ff.single_channel_mode_en;
    alert_n_out             = s_ff.alert_n;
  end

  // ==========================================================================
  // Assertions
  sequence seq_cfg2_write;
    reg_req_in.wr && (reg_req_in.addr == ADDR_CFG2);
  endsequence

  sequence seq_vlow_read;
    reg_req_in.rd && (reg_req_in.addr == ADDR_VLOW);
  endsequence

  sequence seq_tlow_read;
    reg_req_in.rd && (reg_req_in.addr == ADDR_TLOW);
  endsequence

  a_avg_write: assert property (seq_cfg2_write ##0 !config_lock_in
    |=> averaging_disable_out == $past(reg_req_in.wdata[CFG2_AVG_BIT]))
    else $error("averaging disable did not follow write");

  a_attenuator_bypass_write: assert property (seq_cfg2_write ##0 !config_lock_in
    |=> attenuator_bypass_out == $past(reg_req_in.wdata[CFG2_ATTENUATOR_BYPASS_BIT]))
    else $error("attenuator bypass did not follow write");

  a_single_local: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_LOCAL) |=> single_channel_mode_channel_en_out == 5'h08)
    else $error("single channel select did not pick local");

  a_reserved_code: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_RES3) |=> single_channel_mode_channel_en_out == 5'h00)
    else $error("reserved select code enabled a channel");

  a_shutdown_request_pwm_off: assert property (shutdown_request_out
    |=> pwm_out == $past(pwm_polarity_invert_in))
    else $error("pwm not at fan-off level in shutdown");

  a_shutdown_request_duty_zero: assert property (shutdown_request_out
    |=> pwm_duty_view_out == '0)
    else $error("duty view not zero in shutdown");

  a_cfg2_lock_hold: assert property (seq_cfg2_write ##0 config_lock_in
    |=> $stable(s_ff.cfg2))
    else $error("locked configuration changed on write");

  a_core_unmasked: assert property (status_one_in[1] && !s_ff.mask1[1]
    |=> !alert_n_out)
    else $error("unmasked core voltage alert missing");

  a_gate_blocks: assert property (status_one_in == '0 && (&(mask2_view | ~ALERT2_SRC))
    && s_ff.mask1[MASK1_GATE_BIT] |=> alert_n_out)
    else $error("gate bit failed to block status two alert");

  a_ovt_readonly: assert property (reg_req_in.rd && reg_req_in.addr == ADDR_MASK2
    |=> reg_rdata_out[MASK2_OVT_BIT] == $past(overtemp_mask_in))
    else $error("overtemperature mask bit not read-only");

  a_fan_one_fault_mask_masked: assert property (status_one_in == '0 && status_two_vec == 8'h04
    && s_ff.mask2[2] && !s_ff.mask1[MASK1_GATE_BIT] && !(&(mask2_view | ~ALERT2_SRC))
    |=> alert_n_out)
    else $error("masked fan one fault raised alert");

  a_timer_alert: assert property (fan_four_tach_pin_in
    && status_two_in.thermal_timer_event && !s_ff.mask2[MASK2_F4P_BIT] |=> !alert_n_out)
    else $error("thermal timer event alert missing");

  a_diode_alert: assert property (status_two_in.diode_two_fault && !s_ff.mask2[7]
    |=> !alert_n_out)
    else $error("remote two diode fault alert missing");

  a_vlow_layout: assert property (seq_vlow_read
    |=> reg_rdata_out == {2'b00, $past(s_ff.low_bits[1]), $past(s_ff.low_bits[0]), 2'b00})
    else $error("voltage low bits misplaced");

  a_tlow_layout: assert property (seq_tlow_read
    |=> reg_rdata_out == {$past(s_ff.low_bits[4]), $past(s_ff.low_bits[3]),
                          $past(s_ff.low_bits[2]), 2'b00})
    else $error("temperature low bits misplaced");

  a_freeze_hold: assert property (seq_vlow_read ##1 (msb_read_in[0] == 1'b0)
    |=> $stable(msb_hold_out[0]) && $stable(s_ff.low_bits[0]))
    else $error("core reading changed while frozen");

  a_freeze_vlow_edge: assert property (seq_vlow_read
    |=> $stable(msb_hold_out[1:0]))
    else $error("voltage reading changed at its low-bit read");

  a_freeze_tlow_edge: assert property (seq_tlow_read
    |=> $stable(msb_hold_out[4:2]))
    else $error("temperature reading changed at its low-bit read");

  a_update_free: assert property (s_ff.pending == '0 && meas_valid_in
    && !reg_req_in.rd |=> msb_hold_out[0] == $past(reading_in[0][9:2]))
    else $error("free core reading did not update");

  a_single_core: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_CORE) |=> single_channel_mode_channel_en_out == 5'h01)
    else $error("single channel select did not pick core voltage");

  a_single_supply: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_SUPPLY) |=> single_channel_mode_channel_en_out == 5'h02)
    else $error("single channel select did not pick supply voltage");

  a_single_remote_one: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_REMOTE1) |=> single_channel_mode_channel_en_out == 5'h04)
    else $error("single channel select did not pick remote one");

  a_single_remote_two: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_REMOTE2) |=> single_channel_mode_channel_en_out == 5'h10)
    else $error("single channel select did not pick remote two");

  a_reserved_zero: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_RES0) |=> single_channel_mode_channel_en_out == 5'h00)
    else $error("reserved select code zero enabled a channel");

  a_reserved_four: assert property (single_channel_mode_out
    && (fan_one_min_high_in[7:5] == CH_RES4) |=> single_channel_mode_channel_en_out == 5'h00)
    else $error("reserved select code four enabled a channel");

  a_all_channels: assert property (!single_channel_mode_out
    |=> single_channel_mode_channel_en_out == 5'h1F)
    else $error("channels not all enabled outside single mode");

  a_gate_passes: assert property (status_one_in == '0 && (&(mask2_view | ~ALERT2_SRC))
    && (|(status_two_vec & ALERT2_SRC)) && !s_ff.mask1[MASK1_GATE_BIT] |=> !alert_n_out)
    else $error("clear gate bit failed to pass status two alert");

  a_shutdown_request_write: assert property (seq_cfg2_write ##0 !config_lock_in
    |=> shutdown_request_out == $past(reg_req_in.wdata[CFG2_SHUTDOWN_REQUEST_BIT]))
    else $error("shutdown request did not follow write");

  a_pwm_follow: assert property (!shutdown_request_out
    |=> pwm_out == $past(pwm_drive_in))
    else $error("pwm did not follow its drive level");

  a_duty_follow: assert property (!shutdown_request_out
    |=> pwm_duty_view_out == $past(pwm_duty_in))
    else $error("duty view did not follow duty register");

  a_masked_core: assert property (status_one_in == 8'h02 && s_ff.mask1[1]
    && status_two_vec == 8'h00 |=> alert_n_out)
    else $error("masked core voltage condition raised alert");

endmodule

/* File: tb/mcar_host_model.sv */
// Host stand-in: strobed register requests and high-byte read pulses
`timescale 1ns/1ps
module mcar_host_model
  import mcar_pkg::*;
(
  input  wire logic         core_clk_in,
  output mcar_reg_req_t     reg_req_out,
  output logic              rd_seen_out,
  output logic [NUM_CH-1:0] msb_read_out
);
  initial begin
    reg_req_out  = '0;
    rd_seen_out  = 1'b0;
    msb_read_out = '0;
  end

  // ==========================================================================
  // Marks the edge at which read data becomes valid
  always @(posedge core_clk_in) begin
    rd_seen_out <= reg_req_out.rd;
  end

  // ==========================================================================
  // One register access, then one idle cycle; released address and data show inverted values, strobes go low
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    reg_req_out.addr  = a;
    reg_req_out.wdata = d;
    reg_req_out.wr    = w;
    reg_req_out.rd    = ~w;
    @(posedge core_clk_in);
    #2;
    reg_req_out.wr    = 1'b0;
    reg_req_out.rd    = 1'b0;
    reg_req_out.addr  = ~a;
    reg_req_out.wdata = ~d;
    @(posedge core_clk_in);
    #2;
  endtask

  // ==========================================================================
  // High byte read of one channel, issued after its low bits were read
  task automatic read_high(input int unsigned ch);
    msb_read_out[ch] = 1'b1;
    @(posedge core_clk_in);
    #2;
    msb_read_out[ch] = 1'b0;
    @(posedge core_clk_in);
    #2;
  endtask
endmodule

/* File: tb/mcar_regs_tb.sv */
// Self-checking bench of the configuration and alert mask register group
`timescale 1ns/1ps
module mcar_regs_tb
  import mcar_pkg::*;
;
  logic                    core_clk = 1'b0;
  logic                    rst_n;
  mcar_reg_req_t           req;
  logic [7:0]              rdata;
  logic                    lock, meas_valid, tach, ovt_mask, rd_seen;
  logic [7:0]              fan_min_high, status_one, v;
  logic [NUM_CH-1:0][9:0]  reading, old_rd;
  logic [NUM_CH-1:0]       msb_read, single_channel_mode_en;
  logic [NUM_CH-1:0][7:0]  msb_hold;
  logic [NUM_PWM-1:0]      pwm_drive, pwm_inv, pwm;
  logic [NUM_PWM-1:0][7:0] pwm_duty, duty_view;
  mcar_status_two_t        status_two;
  logic                    averaging_disable, attenuator_bypass, single, shutdown_request, alert_n;
  logic [7:0]              exp_q[$];
  logic [4:0]              sel_tab [8] = '{5'h00, 5'h01, 5'h02, 5'h00, 5'h00, 5'h04, 5'h08, 5'h10};
  int                      err_total = 0;
  int                      compares = 0;
  int                      seed;
  int unsigned             mb;

  always #12.5 core_clk = ~core_clk;

  mcar_host_model mcar_host_model_i (.core_clk_in(core_clk), .reg_req_out(req),
    .rd_seen_out(rd_seen), .msb_read_out(msb_read));

  mcar_regs mcar_regs_i (.core_clk_in(core_clk), .rst_n_in(rst_n), .reg_req_in(req),
    .reg_rdata_out(rdata), .config_lock_in(lock), .fan_one_min_high_in(fan_min_high),
    .reading_in(reading), .meas_valid_in(meas_valid), .msb_read_in(msb_read),
    .msb_hold_out(msb_hold), .pwm_drive_in(pwm_drive), .pwm_polarity_invert_in(pwm_inv),
    .pwm_duty_in(pwm_duty), .pwm_out(pwm), .pwm_duty_view_out(duty_view),
    .status_one_in(status_one), .status_two_in(status_two), .fan_four_tach_pin_in(tach),
    .overtemp_mask_in(ovt_mask), .averaging_disable_out(averaging_disable), .attenuator_bypass_out(attenuator_bypass),
    .single_channel_mode_out(single), .shutdown_request_out(shutdown_request),
    .single_channel_mode_channel_en_out(single_channel_mode_en), .alert_n_out(alert_n));

  // ==========================================================================
  // Shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    mcar_host_model_i.access(a, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mcar_host_model_i.access(a, d, 1'b1);
  endtask

  task automatic new_reading;
    for (int c = 0; c < NUM_CH; c++) reading[c] = 10'($random(seed));
    meas_valid = 1'b1;
    step(1);
    meas_valid = 1'b0;
    step(2);
  endtask

  // ==========================================================================
  // Read data monitor: oldest note against the data of each read
  always @(negedge core_clk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("BAD %0t: read data without a note", $time);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("BAD %0t: run did not finish", $time);
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 41485;
    {rst_n, lock, meas_valid, tach, ovt_mask} = '0;
    {fan_min_high, status_one, reading, pwm_duty} = '0;
    status_two = '0;
    pwm_drive = 3'h5;
    pwm_inv = 3'h0;
    repeat (12) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    rd_exp(ADDR_CFG2, CFG2_RST);
    rd_exp(ADDR_MASK1, MASK1_RST);
    rd_exp(ADDR_MASK2, MASK2_RST);
    rd_exp(8'h50, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      v[7] = i[0];
      pwm_drive = 3'($random(seed));
      pwm_inv = 3'($random(seed));
      pwm_duty = 24'($random(seed));
      wr(ADDR_CFG2, v);
      rd_exp(ADDR_CFG2, v & CFG2_WR_MASK);
      check({4'h0, shutdown_request, single, attenuator_bypass, averaging_disable}, {4'h0, v[7:4]});
      check({5'h00, pwm}, {5'h00, v[7] ? pwm_inv : pwm_drive});
      for (int p = 0; p < NUM_PWM; p++) check(duty_view[p], v[7] ? 8'h00 : pwm_duty[p]);
    end
    wr(ADDR_CFG2, 8'h40);
    for (int c = 0; c < 8; c++) begin
      fan_min_high = {3'(c), 5'($random(seed))};
      step(2);
      check({3'h0, single_channel_mode_en}, {3'h0, sel_tab[c]});
    end
    lock = 1'b1;
    wr(ADDR_CFG2, 8'h90);
    rd_exp(ADDR_CFG2, 8'h40);
    lock = 1'b0;
    wr(ADDR_CFG2, 8'h00);
    check({3'h0, single_channel_mode_en}, 8'h1F);
    wr(ADDR_MASK1, 8'hFF);
    rd_exp(ADDR_MASK1, 8'hF6);
    ovt_mask = 1'b1;
    wr(ADDR_MASK2, 8'hFF);
    rd_exp(ADDR_MASK2, 8'hFE);
    status_two.fan_fault = 3'h1;
    step(2);
    check({7'h00, alert_n}, 8'h01);
    wr(ADDR_MASK1, 8'h76);
    check({7'h00, alert_n}, 8'h00);
    {status_two, ovt_mask} = '0;
    wr(ADDR_MASK1, 8'h00);
    wr(ADDR_MASK2, 8'h00);
    for (int b = 0; b < 8; b++) begin
      if (ALERT1_SRC[b]) begin
        status_one = 8'h01 << b;
        step(2);
        check({7'h00, alert_n}, 8'h00);
        wr(ADDR_MASK1, 8'h01 << b);
        check({7'h00, alert_n}, 8'h01);
        status_one = 8'h00;
        wr(ADDR_MASK1, 8'h00);
      end
    end
    for (int j = 0; j < 8; j++) begin
      mb = (j == 0) ? 1 : (j <= 3) ? j + 1 : (j == 4) ? 5 : j;
      tach = (j == 5);
      status_two = mcar_status_two_t'(8'h01 << j);
      step(2);
      check({7'h00, alert_n}, 8'h00);
      if (j == 0) ovt_mask = 1'b1;
      else wr(ADDR_MASK2, 8'h01 << mb);
      step(2);
      check({7'h00, alert_n}, 8'h01);
      {status_two, ovt_mask} = '0;
      wr(ADDR_MASK2, 8'h00);
    end
    new_reading();
    wr(ADDR_VLOW, 8'hFF);
    rd_exp(ADDR_VLOW, {2'b00, reading[1][1:0], reading[0][1:0], 2'b00});
    rd_exp(ADDR_TLOW, {reading[4][1:0], reading[3][1:0], reading[2][1:0], 2'b00});
    old_rd = reading;
    new_reading();
    for (int c = 0; c < NUM_CH; c++) check(msb_hold[c], old_rd[c][9:2]);
    for (int c = 0; c < NUM_CH; c++) mcar_host_model_i.read_high(c);
    new_reading();
    for (int c = 0; c < NUM_CH; c++) check(msb_hold[c], reading[c][9:2]);
    rd_exp(ADDR_VLOW, {2'b00, reading[1][1:0], reading[0][1:0], 2'b00});
    for (int c = 0; c < 2; c++) mcar_host_model_i.read_high(c);
    old_rd = reading;
    for (int c = 0; c < NUM_CH; c++) reading[c] = 10'($random(seed));
    meas_valid = 1'b1;
    rd_exp(ADDR_VLOW, {2'b00, old_rd[1][1:0], old_rd[0][1:0], 2'b00});
    meas_valid = 1'b0;
    for (int c = 0; c < 2; c++) check(msb_hold[c], old_rd[c][9:2]);
    check(msb_hold[2], reading[2][9:2]);
    for (int k = 0; k < 8 && exp_q.size() > 0; k++) step(1);
    if (exp_q.size() > 0) begin
      err_total++;
      $display("BAD %0t: %0d read notes left unanswered", $time, exp_q.size());
    end
    stop_test();
  end
endmodule
